/* verilog/sbsr_status_bank.v */
`timescale 1ns/1ps
`include "sbsr_consts.vh"
// How it works
// R1 - Each of the four branches owns one read-only status word holding only its own state.
// R2 - Bits 11 to 9 give the branch mode code, 0 normal up to 5 send-only variant a.
// R3 - Bit 8 sets on a remote wake detection and raises the wake and branch event interrupts.
// R4 - Bit 8 clears after a good read of its word or when the star drops from normal to standby or sleep.
// R5 - Bit 6 sets on a transmit/receive mismatch while the branch is in normal mode and raises the branch event interrupt.
// R6 - With holding on, bit 6 stays until read, then clears on a clean frame or leaving normal.
// R7 - With holding off, bit 6 clears on a clean frame or when the branch leaves normal.
// R8 - Bit 4 sets when the branch stays stuck past the detect time, raising clamp and event irqs.
// R9 - With holding on, bit 4 stays until read and then clears once idle is seen.
// R10 - With holding off, bit 4 clears whenever idle is seen.
// R11 - Bit 0 makes the total count of ones in the word odd.
// R12 - Bits 7, 5, 3 and 1 read zero and bit 2 reads one.
// R13 - Only a read frame that ends without error counts as a read of its word, and events in its last cycle win.
module sbsr_status_bank
#(
  parameter NUM_BRANCH = 4
)
(
  input wire core_clk_in,
  input wire reset_in,
  input wire latch_en_in,
  input wire star_normal_mode_in,
  input wire star_standby_mode_in,
  input wire star_sleep_mode_in,
  input wire [3*NUM_BRANCH-1:0] branch_mode_code_in,
  input wire [NUM_BRANCH-1:0] wake_det_in,
  input wire [NUM_BRANCH-1:0] mismatch_det_in,
  input wire [NUM_BRANCH-1:0] clean_frame_in,
  input wire [NUM_BRANCH-1:0] stuck_det_in,
  input wire [NUM_BRANCH-1:0] idle_det_in,
  input wire read_start_in,
  input wire [1:0] read_sel_in,
  input wire read_end_in,
  input wire read_err_in,
  output reg [`SBSR_WORD_W-1:0] read_data_out,
  output reg [NUM_BRANCH*`SBSR_WORD_W-1:0] branch_status_word_out,
  output reg wakeup_irq_out,
  output reg clamp_error_irq_out,
  output reg [NUM_BRANCH-1:0] branch_event_irq_out
);

// ========================================
// Read frame tracking
// ========================================
// Word is captured at frame start so the host sees a stable value
reg frame_active_r;
reg [1:0] frame_sel_r;
reg frame_err_r;
reg prev_star_normal_r;
wire star_sleep_entry;
wire [NUM_BRANCH-1:0] wake_flag;
wire [NUM_BRANCH-1:0] txm_flag;
wire [NUM_BRANCH-1:0] stuck_flag;
wire [NUM_BRANCH-1:0] wake_set;
wire [NUM_BRANCH-1:0] txm_set;
wire [NUM_BRANCH-1:0] stuck_set;
wire [NUM_BRANCH*`SBSR_WORD_W-1:0] word_live;
reg [NUM_BRANCH-1:0] read_done;

assign star_sleep_entry = prev_star_normal_r & ~star_normal_mode_in &
  (star_standby_mode_in | star_sleep_mode_in);

always @*
begin
  read_done = {NUM_BRANCH{1'b0}};
  if (frame_active_r && read_end_in && !read_err_in && !frame_err_r)
    read_done[frame_sel_r] = 1'b1; // see R13
end

always @(posedge core_clk_in)
begin
  if (reset_in)
  begin
    frame_active_r <= 1'b0;
    frame_sel_r <= 2'h0;
    frame_err_r <= 1'b0;
    prev_star_normal_r <= 1'b0;
    read_data_out <= {`SBSR_WORD_W{1'b0}};
  end
  else
  begin
    prev_star_normal_r <= star_normal_mode_in;
    if (read_start_in)
    begin
      frame_active_r <= 1'b1;
      frame_sel_r <= read_sel_in;
      frame_err_r <= read_err_in;
      read_data_out <= word_live[read_sel_in*`SBSR_WORD_W +: `SBSR_WORD_W];
    end
    else if (read_end_in)
    begin
      frame_active_r <= 1'b0;
      frame_err_r <= 1'b0;
    end
    else if (read_err_in)
      frame_err_r <= 1'b1;
  end
end

// ========================================
// Per-branch flags and words
// ========================================
genvar gi;
generate
  for (gi = 0; gi < NUM_BRANCH; gi = gi + 1)
  begin : g_br
    wire [2:0] mode;
    wire [`SBSR_WORD_W-2:0] body;
    assign mode = branch_mode_code_in[3*gi +: 3];

    sbsr_branch_flags u_flags
    (
      .core_clk_in(core_clk_in),
      .reset_in(reset_in),
      .latch_en_in(latch_en_in),
      .star_sleep_entry_in(star_sleep_entry),
      .mode_in(mode),
      .wake_det_in(wake_det_in[gi]),
      .mismatch_det_in(mismatch_det_in[gi]),
      .clean_frame_in(clean_frame_in[gi]),
      .stuck_det_in(stuck_det_in[gi]),
      .idle_det_in(idle_det_in[gi]),
      .read_done_in(read_done[gi]),
      .wake_flag_out(wake_flag[gi]),
      .txm_flag_out(txm_flag[gi]),
      .stuck_flag_out(stuck_flag[gi]),
      .wake_set_out(wake_set[gi]),
      .txm_set_out(txm_set[gi]),
      .stuck_set_out(stuck_set[gi])
    );

    // Bits 11..1; reserved bits fixed
    assign body = {mode, wake_flag[gi], 1'b0, txm_flag[gi], 1'b0,
      stuck_flag[gi], 1'b0, 1'b1, 1'b0}; // see R1 see R2 see R12
    assign word_live[gi*`SBSR_WORD_W +: `SBSR_WORD_W] = {body, ~(^body)}; // see R11
  end
endgenerate

// ========================================
// Interrupt pulses and visible words
// ========================================
always @(posedge core_clk_in)
begin
  if (reset_in)
  begin
    wakeup_irq_out <= 1'b0;
    clamp_error_irq_out <= 1'b0;
    branch_event_irq_out <= {NUM_BRANCH{1'b0}};
    branch_status_word_out <= {NUM_BRANCH*`SBSR_WORD_W{1'b0}};
  end
  else
  begin
    wakeup_irq_out <= |wake_set; // see R3
    clamp_error_irq_out <= |stuck_set; // see R8
    branch_event_irq_out <= wake_set | txm_set | stuck_set; // see R5
    branch_status_word_out <= word_live;
  end
end

endmodule

/* verilog/sbsr_consts.vh */
`ifndef SBSR_CONSTS_VH
`define SBSR_CONSTS_VH

// Status word layout
`define SBSR_WORD_W 12
`define SBSR_MODE_HI 11
`define SBSR_MODE_LO 9
`define SBSR_WAKE_BIT 8
`define SBSR_TXM_BIT 6
`define SBSR_STUCK_BIT 4
`define SBSR_FIXED_ONE_BIT 2
`define SBSR_PARITY_BIT 0

// Branch mode codes
`define SBSR_MODE_NORMAL 3'h0
`define SBSR_MODE_DISABLED 3'h1
`define SBSR_MODE_LOW_POWER 3'h2
`define SBSR_MODE_SEND_ONLY_B 3'h3
`define SBSR_MODE_FAIL_SILENT 3'h4
`define SBSR_MODE_SEND_ONLY_A 3'h5

// Reset values
`define SBSR_FLAG_RST 1'h0
`define SBSR_MODE_RST 3'h1

`endif

/* verilog/sbsr_branch_flags.v */
`timescale 1ns/1ps
module sbsr_branch_flags
(
  input wire core_clk_in,
  input wire reset_in,
  input wire latch_en_in,
  input wire star_sleep_entry_in,
  input wire [2:0] mode_in,
  input wire wake_det_in,
  input wire mismatch_det_in,
  input wire clean_frame_in,
  input wire stuck_det_in,
  input wire idle_det_in,
  input wire read_done_in,
  output reg wake_flag_out,
  output reg txm_flag_out,
  output reg stuck_flag_out,
  output reg wake_set_out,
  output reg txm_set_out,
  output reg stuck_set_out
);

`include "sbsr_consts.vh"

// ========================================
// Flag state
// ========================================
reg txm_held_r;
reg stuck_held_r;
wire not_normal;
reg wake_nxt;
reg txm_nxt;
reg stuck_nxt;
reg txm_held_nxt;
reg stuck_held_nxt;

assign not_normal = (mode_in != `SBSR_MODE_NORMAL);

always @*
begin
  // Wake: cleared by read or star leaving normal, set wins
  wake_nxt = wake_flag_out;
  if (read_done_in || star_sleep_entry_in)
    wake_nxt = 1'b0; // see R4
  if (wake_det_in)
    wake_nxt = 1'b1; // see R3
  // Mismatch: held flag blocks the live clear until a read
  txm_held_nxt = txm_held_r;
  txm_nxt = txm_flag_out;
  if (read_done_in)
    txm_held_nxt = 1'b0;
  if ((!txm_held_nxt || !latch_en_in) && (clean_frame_in || not_normal))
    txm_nxt = 1'b0; // see R6 see R7
  if (mismatch_det_in && !not_normal)
  begin
    txm_nxt = 1'b1; // see R5
    txm_held_nxt = 1'b1;
  end
  // Stuck: same hold scheme, released by idle
  stuck_held_nxt = stuck_held_r;
  stuck_nxt = stuck_flag_out;
  if (read_done_in)
    stuck_held_nxt = 1'b0;
  if ((!stuck_held_nxt || !latch_en_in) && idle_det_in)
    stuck_nxt = 1'b0; // see R9 see R10
  if (stuck_det_in)
  begin
    stuck_nxt = 1'b1; // see R8
    stuck_held_nxt = 1'b1;
  end
end

always @(posedge core_clk_in)
begin
  if (reset_in)
  begin
    wake_flag_out <= `SBSR_FLAG_RST;
    txm_flag_out <= `SBSR_FLAG_RST;
    stuck_flag_out <= `SBSR_FLAG_RST;
    txm_held_r <= 1'b0;
    stuck_held_r <= 1'b0;
    wake_set_out <= 1'b0;
    txm_set_out <= 1'b0;
    stuck_set_out <= 1'b0;
  end
  else
  begin
    wake_flag_out <= wake_nxt;
    txm_flag_out <= txm_nxt;
    stuck_flag_out <= stuck_nxt;
    txm_held_r <= txm_held_nxt;
    stuck_held_r <= stuck_held_nxt;
    wake_set_out <= wake_nxt & ~wake_flag_out;
    txm_set_out <= txm_nxt & ~txm_flag_out;
    stuck_set_out <= stuck_nxt & ~stuck_flag_out;
  end
end

endmodule

/* tb/sbsr_host_model.sv */
`timescale 1ns/1ps
// ====
// Host end of the serial status port
module sbsr_host_model
(
  input wire core_clk_in,
  output reg read_start_out,
  output reg [1:0] read_sel_out,
  output reg read_end_out,
  output reg read_err_out
);
  initial {read_start_out, read_sel_out, read_end_out, read_err_out} = 5'h00;
  // Idle lead-in lets the previous frame's clear reach the live words
  task rd(input [1:0] b, input e);
  begin
    repeat (3) @(negedge core_clk_in);
    read_start_out = 1'h1;
    read_sel_out = b;
    @(negedge core_clk_in);
    read_start_out = 1'h0;
    @(negedge core_clk_in);
    {read_end_out, read_err_out} = {1'h1, e};
    @(negedge core_clk_in);
    {read_end_out, read_err_out} = 2'h0;
  end
  endtask
endmodule

/* tb/sbsr_status_bank_monitor.sv */
`timescale 1ns/1ps
`include "sbsr_consts.vh"
// ====
// Status bank checker
module sbsr_status_bank_monitor
#(
  parameter NUM_BRANCH = 4
)
(
  input wire core_clk_in,
  input wire reset_in,
  input wire star_normal_mode_in,
  input wire [NUM_BRANCH-1:0] wake_det_in,
  input wire read_start_in,
  input wire read_end_in,
  input wire read_err_in,
  input wire [`SBSR_WORD_W-1:0] read_data_out,
  input wire [NUM_BRANCH*`SBSR_WORD_W-1:0] branch_status_word_out,
  input wire wakeup_irq_out,
  input wire clamp_error_irq_out,
  input wire [NUM_BRANCH-1:0] branch_event_irq_out
);
  wire [11:0] w0 = branch_status_word_out[11:0];
  wire ev0 = branch_event_irq_out[0];
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  fixed_bits_a: assert property (!$past(reset_in) && !$past(reset_in, 2) |->
    ({4{12'h0ae}} & branch_status_word_out) == {4{12'h004}}) else $error("fixed bits wrong");
  parity_odd_a: assert property (!$past(reset_in) && !$past(reset_in, 2) |->
    ^w0 && ^branch_status_word_out[47:36]) else $error("even parity");
  wake_set_a: assert property (wake_det_in[0] |-> ##2 w0[8])
    else $error("wake flag not set");
  wake_irq_a: assert property ($rose(w0[8]) |-> wakeup_irq_out && ev0)
    else $error("wake irq missing");
  stuck_irq_a: assert property ($rose(w0[4]) |-> clamp_error_irq_out && ev0)
    else $error("clamp irq missing");
  txm_irq_a: assert property ($rose(w0[6]) |-> ev0)
    else $error("event irq missing");
  read_hold_a: assert property (!read_start_in |=> $stable(read_data_out))
    else $error("read data moved");
  star_clear_a: assert property ($fell(star_normal_mode_in) && !wake_det_in[0] |->
    ##[1:3] !w0[8]) else $error("wake flag kept");
  cover property (wakeup_irq_out);
  cover property (clamp_error_irq_out);
  cover property (read_end_in && read_err_in);
endmodule
bind sbsr_status_bank sbsr_status_bank_monitor #(.NUM_BRANCH(NUM_BRANCH)) mon (.*);

/* tb/tb_sbsr_status_bank.sv */
`timescale 1ns/1ps
// ====
// Status bank bench
module tb_sbsr_status_bank;
  reg clk = 1'h0;
  reg rst = 1'h1;
  reg lat = 1'h1;
  reg nrm = 1'h1;
  reg sby = 1'h0;
  reg [11:0] md = 12'h000;
  reg [3:0] wk = 4'h0, mm = 4'h0, cf = 4'h0, sk = 4'h0, id = 4'h0;
  wire st, en, er;
  wire [1:0] sl;
  wire [11:0] rdat;
  integer num_errors = 0, checks = 0, k, b;
  reg [11:0] q[$];
  always #5 clk = ~clk;
  sbsr_host_model host (.core_clk_in(clk), .read_start_out(st), .read_sel_out(sl),
    .read_end_out(en), .read_err_out(er));
  sbsr_status_bank dut (.core_clk_in(clk), .reset_in(rst), .latch_en_in(lat),
    .star_normal_mode_in(nrm), .star_standby_mode_in(sby), .star_sleep_mode_in(1'h0),
    .branch_mode_code_in(md), .wake_det_in(wk), .mismatch_det_in(mm), .clean_frame_in(cf),
    .stuck_det_in(sk), .idle_det_in(id), .read_start_in(st), .read_sel_in(sl),
    .read_end_in(en), .read_err_in(er), .read_data_out(rdat), .branch_status_word_out(),
    .wakeup_irq_out(), .clamp_error_irq_out(), .branch_event_irq_out());
  task chk(input [11:0] s, input [11:0] e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("BAD read_data_out exp %h got %h", e, s);
    end
  end
  endtask
  // Expected word from mode shadow and {wake, mismatch, stuck}
  task rd(input [1:0] b, input e, input [2:0] f);
    reg [11:0] w;
  begin
    w = {md[3*b+:3], f[2], 1'h0, f[1], 1'h0, f[0], 3'h2, 1'h0};
    w[0] = ~^w;
    q.push_back(w);
    host.rd(b, e);
  end
  endtask
  // One-cycle pulse on event group t: 0 wake, 1 mismatch, 2 clean, 3 stuck, 4 idle
  task ev(input integer t, input [3:0] m);
  begin
    @(negedge clk);
    {wk, mm, cf, sk, id} = {16'h0000, m} << (16 - 4 * t);
    @(negedge clk);
    {wk, mm, cf, sk, id} = 20'h0_0000;
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  always @(posedge clk)
    if (st)
    begin
      @(negedge clk);
      chk(rdat, q.pop_front());
    end
  initial
  begin
    #50000;
    num_errors = num_errors + 1;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'h5e4f_b5d9));
    repeat (4) @(negedge clk);
    rst = 1'h0;
    for (k = 0; k < 6; k = k + 1)
    begin
      for (b = 0; b < 4; b = b + 1)
        md[3*b+:3] = 3'((k + b) % 6);
      for (b = 0; b < 4; b = b + 1)
        rd(b[1:0], 1'h0, 3'h0);
    end
    md = 12'h000;
    b = $urandom % 4;
    ev(0, 4'h1 << b);
    rd(b[1:0], 1'h1, 3'h4);
    rd(b[1:0], 1'h0, 3'h4);
    rd(b[1:0], 1'h0, 3'h0);
    ev(0, 4'hf);
    repeat (2) @(negedge clk);
    {nrm, sby} = 2'h1;
    rd(b[1:0], 1'h0, 3'h0);
    {nrm, sby} = 2'h2;
    b = 0;
    ev(1, 4'h1);
    ev(2, 4'hf);
    rd(2'h0, 1'h0, 3'h2);
    ev(2, 4'hf);
    rd(2'h0, 1'h0, 3'h0);
    lat = 1'h0;
    ev(1, 4'h1);
    ev(2, 4'hf);
    rd(2'h0, 1'h0, 3'h0);
    ev(1, 4'h1);
    md[2:0] = 3'h1;
    rd(2'h0, 1'h0, 3'h0);
    lat = 1'h1;
    ev(3, 4'h1);
    ev(4, 4'hf);
    rd(2'h0, 1'h0, 3'h1);
    ev(4, 4'hf);
    rd(2'h0, 1'h0, 3'h0);
    lat = 1'h0;
    ev(3, 4'h1);
    ev(4, 4'hf);
    rd(2'h0, 1'h0, 3'h0);
    repeat (4) @(negedge clk);
    tally_and_finish;
  end
endmodule
